// >>> rtl/pmc_ctrl.sv
`timescale 1ns/1ps
module pmc_ctrl import pmc_pkg::*; (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input wire logic [1:0] REQ_MODE,
    input wire logic CORE_IRQ,
    input wire logic [2:0] EXT_WAKE_IRQ_LINE,
    input wire logic SERIAL_RX_WAKE,
    input wire logic RTC_SECONDS_UNIT,
    input wire logic RTC_PRESCALED_UNIT,
    input wire logic [WAKE_N-1:0] WAKE_EN,
    input wire logic RET_DATA_EXTRA,
    input wire logic RET_INSTR_PAIR,
    input wire logic GPIO_CFG_DONE,
    output logic [1:0] MODE,
    output logic CORE_CLK_EN,
    output logic CORE_RUN,
    output logic SYS_CLK_EN,
    output logic DMA_CLK_EN,
    output logic PERIPH_PWR_EN,
    output logic STATE_RET_EN,
    output logic [BANK_N-1:0] SRAM_PWR_EN,
    output logic [BANK_N-1:0] SRAM_RET_EN,
    output logic GPIO_HOLD,
    output logic GPIO_CFG_RET,
    output logic GPIO_CFG_CLEAR,
    output logic GPIO_TRISTATE,
    output logic ICACHE_INVAL
);
    typedef enum logic [3:0] {
        S_ACTIVE,
        S_CORE_GATED,
        S_HIB_ENTER,
        S_HIB,
        S_SD_ENTER,
        S_SD,
        S_PWR_UP,
        S_CLK_UP
    } pmcc_fsm_t;

    typedef struct packed {
        pmcc_fsm_t fsm;
        logic [CNT_W-1:0] cnt;
        logic from_sd;
        logic [1:0] mode;
        logic core_clk;
        logic core_run;
        logic sys_clk;
        logic dma_clk;
        logic periph_pwr;
        logic state_ret;
        logic [BANK_N-1:0] sram_pwr;
        logic [BANK_N-1:0] sram_ret;
        logic gpio_hold;
        logic gpio_cfg_ret;
        logic gpio_cfg_clear;
        logic gpio_tri;
        logic icache_inval;
    } pmcc_state_t;

    pmcc_state_t st_q;
    pmcc_state_t st_d;

    pmc_wake_if wif ();

    pmc_wake_gate u_wake (
        .clk(MCLK),
        .rst_n(RST_N),
        .wif(wif)
    );

    // Raw pin levels; the gate module synchronises them before use
    assign wif.raw = {RTC_PRESCALED_UNIT, RTC_SECONDS_UNIT, SERIAL_RX_WAKE,
                      EXT_WAKE_IRQ_LINE};
    assign wif.enable = WAKE_EN;
    assign wif.in_hib = (st_q.fsm == S_HIB_ENTER) || (st_q.fsm == S_HIB);
    assign wif.in_sd = (st_q.fsm == S_SD_ENTER) || (st_q.fsm == S_SD);

    // Banks kept in hibernate; the first bank cannot be dropped
    function automatic logic [BANK_N-1:0] ret_banks(input logic data_x, input logic instr_x);
        ret_banks = BANK_ALWAYS;
        if (data_x) begin
            ret_banks = ret_banks | BANK_DATA_EXTRA;
        end
        if (instr_x) begin
            ret_banks = ret_banks | BANK_INSTR_PAIR;
        end
    endfunction

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n - 1);
    endfunction

    always_comb begin
        logic [BANK_N-1:0] keep;
        keep = ret_banks(RET_DATA_EXTRA, RET_INSTR_PAIR);
        st_d = st_q;
        st_d.gpio_cfg_clear = 1'b0;
        st_d.icache_inval = 1'b0;
        if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
        if (GPIO_CFG_DONE) begin
            st_d.gpio_tri = 1'b0;
        end
        case (st_q.fsm)
            S_ACTIVE: begin
                if (REQ_VALID && REQ_MODE == REQ_CORE_GATED) begin
                    st_d.fsm = S_CORE_GATED;
                end else if (REQ_VALID && REQ_MODE == REQ_HIBERNATE) begin
                    st_d.fsm = S_HIB_ENTER;
                    st_d.cnt = cyc(ENTRY_CYC);
                end else if (REQ_VALID && REQ_MODE == REQ_SHUTDOWN) begin
                    st_d.fsm = S_SD_ENTER;
                    st_d.cnt = cyc(ENTRY_CYC);
                end
            end
            S_CORE_GATED: begin
                // Any core interrupt ends the gated period
                if (CORE_IRQ || (REQ_VALID && REQ_MODE == REQ_ACTIVE)) begin
                    st_d.fsm = S_ACTIVE;
                end
            end
            S_HIB_ENTER: begin
                if (wif.wake) begin
                    st_d.fsm = S_CLK_UP;
                    st_d.from_sd = 1'b0;
                    st_d.cnt = cyc(CLK_SETTLE_CYC);
                end else if (st_q.cnt == '0) begin
                    st_d.fsm = S_HIB;
                end
            end
            S_SD_ENTER: begin
                if (wif.wake) begin
                    st_d.fsm = S_CLK_UP;
                    st_d.from_sd = 1'b0;
                    st_d.cnt = cyc(CLK_SETTLE_CYC);
                end else if (st_q.cnt == '0) begin
                    st_d.fsm = S_SD;
                end
            end
            S_HIB, S_SD: begin
                if (wif.wake) begin
                    st_d.fsm = S_PWR_UP;
                    st_d.from_sd = (st_q.fsm == S_SD);
                    st_d.cnt = cyc(PWR_SETTLE_CYC);
                end
            end
            S_PWR_UP: begin
                if (st_q.cnt == '0) begin
                    st_d.fsm = S_CLK_UP;
                    st_d.cnt = cyc(CLK_SETTLE_CYC);
                end
            end
            S_CLK_UP: begin
                if (st_q.cnt == '0) begin
                    st_d.fsm = S_ACTIVE;
                    st_d.icache_inval = 1'b1;
                    if (st_q.from_sd) begin
                        // Pin setup was lost; keep pins floating until rewritten
                        st_d.gpio_cfg_clear = 1'b1;
                        st_d.gpio_tri = 1'b1;
                    end
                end
            end
            default: begin
                st_d.fsm = S_ACTIVE;
            end
        endcase

        // Outputs follow the next state so they leave flip-flops
        st_d.core_clk = 1'b0;
        st_d.core_run = 1'b0;
        st_d.sys_clk = 1'b0;
        st_d.dma_clk = 1'b0;
        st_d.periph_pwr = 1'b0;
        st_d.state_ret = 1'b0;
        st_d.sram_pwr = BANK_ALL;
        st_d.sram_ret = '0;
        st_d.gpio_hold = 1'b0;
        st_d.gpio_cfg_ret = 1'b0;
        case (st_d.fsm)
            S_ACTIVE: begin
                st_d.mode = PMC_MODE_ACTIVE;
                st_d.core_clk = 1'b1;
                st_d.core_run = 1'b1;
                st_d.sys_clk = 1'b1;
                st_d.dma_clk = 1'b1;
                st_d.periph_pwr = 1'b1;
            end
            S_CORE_GATED: begin
                st_d.mode = PMC_MODE_CORE_GATED;
                st_d.sys_clk = 1'b1;
                st_d.dma_clk = 1'b1;
                st_d.periph_pwr = 1'b1;
            end
            S_HIB_ENTER, S_HIB: begin
                st_d.mode = PMC_MODE_HIBERNATE;
                st_d.state_ret = 1'b1;
                st_d.sram_ret = keep;
                st_d.sram_pwr = keep;
                st_d.gpio_hold = 1'b1;
                st_d.gpio_cfg_ret = 1'b1;
            end
            S_SD_ENTER, S_SD: begin
                st_d.mode = PMC_MODE_SHUTDOWN;
                st_d.sram_pwr = '0;
                st_d.gpio_hold = 1'b1;
            end
            default: begin
                // SRAM power and then the system clock come back while the core stays halted
                st_d.sys_clk = (st_d.fsm == S_CLK_UP);
                st_d.state_ret = !st_d.from_sd;
                st_d.sram_ret = st_d.from_sd ? '0 : keep;
                st_d.gpio_hold = 1'b1;
                st_d.gpio_cfg_ret = !st_d.from_sd;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= '0;
            st_q.fsm <= S_ACTIVE;
            st_q.mode <= PMC_MODE_ACTIVE;
            st_q.core_clk <= 1'b1;
            st_q.core_run <= 1'b1;
            st_q.sys_clk <= 1'b1;
            st_q.dma_clk <= 1'b1;
            st_q.periph_pwr <= 1'b1;
            st_q.sram_pwr <= BANK_ALL;
            st_q.gpio_tri <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign MODE = st_q.mode;
    assign CORE_CLK_EN = st_q.core_clk;
    assign CORE_RUN = st_q.core_run;
    assign SYS_CLK_EN = st_q.sys_clk;
    assign DMA_CLK_EN = st_q.dma_clk;
    assign PERIPH_PWR_EN = st_q.periph_pwr;
    assign STATE_RET_EN = st_q.state_ret;
    assign SRAM_PWR_EN = st_q.sram_pwr;
    assign SRAM_RET_EN = st_q.sram_ret;
    assign GPIO_HOLD = st_q.gpio_hold;
    assign GPIO_CFG_RET = st_q.gpio_cfg_ret;
    assign GPIO_CFG_CLEAR = st_q.gpio_cfg_clear;
    assign GPIO_TRISTATE = st_q.gpio_tri;
    assign ICACHE_INVAL = st_q.icache_inval;
endmodule

// >>> rtl/pmc_pkg.sv
package pmc_pkg;

    localparam int CLK_MHZ = 125;

    // Settling times of the power switches and clock tree
    localparam int ENTRY_NS = 80;
    localparam int PWR_SETTLE_NS = 2000;
    localparam int CLK_SETTLE_NS = 400;
    localparam int ENTRY_CYC = (ENTRY_NS * CLK_MHZ + 999) / 1000;
    localparam int PWR_SETTLE_CYC = (PWR_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CLK_SETTLE_CYC = (CLK_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 9;

    // Mode request codes from the core
    localparam logic [1:0] REQ_ACTIVE = 2'h0;
    localparam logic [1:0] REQ_CORE_GATED = 2'h1;
    localparam logic [1:0] REQ_HIBERNATE = 2'h2;
    localparam logic [1:0] REQ_SHUTDOWN = 2'h3;

    // Wake vector bit positions
    localparam int WAKE_N = 6;
    localparam int W_EXT0 = 0;
    localparam int W_EXT1 = 1;
    localparam int W_EXT2 = 2;
    localparam int W_SERIAL = 3;
    localparam int W_RTC_SEC = 4;
    localparam int W_RTC_PRE = 5;
    localparam logic [WAKE_N-1:0] HIB_WAKE_MASK = 6'h39;
    localparam logic [WAKE_N-1:0] SD_WAKE_MASK = 6'h17;

    // SRAM retention banks, 8 kB each
    localparam int BANK_N = 4;
    localparam logic [BANK_N-1:0] BANK_ALWAYS = 4'h1;
    localparam logic [BANK_N-1:0] BANK_DATA_EXTRA = 4'h2;
    localparam logic [BANK_N-1:0] BANK_INSTR_PAIR = 4'hc;
    localparam logic [BANK_N-1:0] BANK_ALL = 4'hf;

    typedef enum logic [1:0] {
        PMC_MODE_ACTIVE,
        PMC_MODE_CORE_GATED,
        PMC_MODE_HIBERNATE,
        PMC_MODE_SHUTDOWN
    } pmc_mode_t;

endpackage

// >>> rtl/pmc_wake_if.sv
`timescale 1ns/1ps
interface pmc_wake_if;
    import pmc_pkg::*;
    logic [WAKE_N-1:0] raw;
    logic [WAKE_N-1:0] enable;
    logic in_hib;
    logic in_sd;
    logic wake;
    modport ctl (output raw, output enable, output in_hib, output in_sd, input wake);
    modport gate (input raw, input enable, input in_hib, input in_sd, output wake);
endinterface

// >>> rtl/pmc_wake_gate.sv
`timescale 1ns/1ps
module pmc_wake_gate import pmc_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    pmc_wake_if.gate wif
);
    typedef struct packed {
        logic [WAKE_N-1:0] s1;
        logic [WAKE_N-1:0] s2;
        logic wake;
    } pmcw_state_t;

    pmcw_state_t st_q;
    pmcw_state_t st_d;

    // Wake lines are levels, so an event during entry is never lost
    always_comb begin
        logic [WAKE_N-1:0] allowed;
        allowed = '0;
        st_d = st_q;
        st_d.s1 = wif.raw;
        st_d.s2 = st_q.s1;
        if (wif.in_sd) begin
            allowed = SD_WAKE_MASK;
        end else if (wif.in_hib) begin
            allowed = HIB_WAKE_MASK;
        end
        // Seconds alarm left enabled gives periodic wake from shutdown
        st_d.wake = |(st_q.s2 & wif.enable & allowed);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign wif.wake = st_q.wake;
endmodule

// >>> verif/pmc_core_model.sv
`timescale 1ns/1ps
module pmc_core_model (
    input wire logic mclk,
    output logic req_valid,
    output logic [1:0] req_mode,
    output logic core_irq
);
    initial begin
        req_valid = 1'b0;
        req_mode = 2'h0;
        core_irq = 1'b0;
    end
    // Gap lets the core answer late; the code stays put after the strobe
    task automatic request(input logic [1:0] m, input int gap);
        repeat (gap + 1) @(posedge mclk);
        req_valid <= 1'b1;
        req_mode <= m;
        @(posedge mclk);
        req_valid <= 1'b0;
    endtask
    task automatic interrupt();
        @(posedge mclk);
        core_irq <= 1'b1;
        @(posedge mclk);
        core_irq <= 1'b0;
    endtask
endmodule

// >>> verif/pmc_ctrl_assertions.sv
`timescale 1ns/1ps
module pmc_ctrl_checker (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input wire logic [1:0] REQ_MODE,
    input wire logic CORE_IRQ,
    input wire logic RET_DATA_EXTRA,
    input wire logic RET_INSTR_PAIR,
    input wire logic [1:0] MODE,
    input wire logic CORE_CLK_EN,
    input wire logic CORE_RUN,
    input wire logic SYS_CLK_EN,
    input wire logic DMA_CLK_EN,
    input wire logic PERIPH_PWR_EN,
    input wire logic STATE_RET_EN,
    input wire logic [3:0] SRAM_PWR_EN,
    input wire logic [3:0] SRAM_RET_EN,
    input wire logic GPIO_HOLD,
    input wire logic GPIO_CFG_RET,
    input wire logic GPIO_CFG_CLEAR,
    input wire logic GPIO_TRISTATE,
    input wire logic ICACHE_INVAL
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    a_reset_tristate: assert property (
        $rose(RST_N) |-> GPIO_TRISTATE && MODE == 2'h0)
        else $error("pins not tristate after reset");
    a_active_all_on: assert property (
        MODE == 2'h0 |-> CORE_CLK_EN && CORE_RUN && SYS_CLK_EN && DMA_CLK_EN && PERIPH_PWR_EN)
        else $error("active mode with clocks or power off");
    a_gated_core_off: assert property (
        MODE == 2'h1 |-> !CORE_CLK_EN && !CORE_RUN && SYS_CLK_EN && DMA_CLK_EN)
        else $error("core-gated clocks wrong");
    a_gated_irq_exit: assert property (
        MODE == 2'h1 && CORE_IRQ |=> MODE == 2'h0)
        else $error("interrupt did not end core-gated");
    a_hib_entry: assert property (
        REQ_VALID && REQ_MODE == 2'h2 && MODE == 2'h0 |=> MODE == 2'h2
        && STATE_RET_EN && GPIO_HOLD && GPIO_CFG_RET && !CORE_RUN)
        else $error("hibernate entry wrong");
    a_hib_banks: assert property (
        MODE == 2'h2 && !SYS_CLK_EN |-> SRAM_RET_EN ==
        {{2{RET_INSTR_PAIR}}, RET_DATA_EXTRA, 1'b1})
        else $error("retained banks wrong");
    a_sd_entry: assert property (
        REQ_VALID && REQ_MODE == 2'h3 && MODE == 2'h0 |=> MODE == 2'h3
        && !PERIPH_PWR_EN && SRAM_PWR_EN == 4'h0 && GPIO_HOLD && !GPIO_CFG_RET)
        else $error("shutdown entry wrong");
    a_wake_order: assert property (
        MODE == 2'h0 && $past(MODE) > 2'h1 |-> ICACHE_INVAL
        && $past(SYS_CLK_EN) && !$past(CORE_RUN))
        else $error("core resumed before clocks");
    a_inval_pulse: assert property (
        ICACHE_INVAL |=> !ICACHE_INVAL)
        else $error("cache invalidate not a pulse");
    a_cfg_clear: assert property (
        GPIO_CFG_CLEAR |-> GPIO_TRISTATE && $past(MODE) == 2'h3)
        else $error("pin config cleared outside shutdown wake");
endmodule
bind pmc_ctrl pmc_ctrl_checker chk (.MCLK(MCLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID),
    .REQ_MODE(REQ_MODE), .CORE_IRQ(CORE_IRQ), .RET_DATA_EXTRA(RET_DATA_EXTRA),
    .RET_INSTR_PAIR(RET_INSTR_PAIR), .MODE(MODE), .CORE_CLK_EN(CORE_CLK_EN),
    .CORE_RUN(CORE_RUN), .SYS_CLK_EN(SYS_CLK_EN), .DMA_CLK_EN(DMA_CLK_EN),
    .PERIPH_PWR_EN(PERIPH_PWR_EN), .STATE_RET_EN(STATE_RET_EN), .SRAM_PWR_EN(SRAM_PWR_EN),
    .SRAM_RET_EN(SRAM_RET_EN), .GPIO_HOLD(GPIO_HOLD), .GPIO_CFG_RET(GPIO_CFG_RET),
    .GPIO_CFG_CLEAR(GPIO_CFG_CLEAR), .GPIO_TRISTATE(GPIO_TRISTATE), .ICACHE_INVAL(ICACHE_INVAL));

// >>> verif/tb_power_mode_controller.sv
`timescale 1ns/1ps
module tb_power_mode_controller;
    import pmc_pkg::*;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic req_valid, core_irq, cfg_done = 1'b0;
    logic [1:0] req_mode, mode, ret = 2'h0;
    logic [5:0] src = 6'h00;
    logic [5:0] en = 6'h3f;
    logic core_clk, core_run, sys_clk, dma_clk, periph, st_ret, hold, cfg_ret, cfg_clr, tri_st;
    logic inval;
    logic [3:0] sram_pwr, sram_ret;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    pmc_core_model core (.mclk(MCLK), .req_valid(req_valid), .req_mode(req_mode),
        .core_irq(core_irq));
    pmc_ctrl dut (.MCLK(MCLK), .RST_N(RST_N), .REQ_VALID(req_valid), .REQ_MODE(req_mode),
        .CORE_IRQ(core_irq), .EXT_WAKE_IRQ_LINE(src[2:0]), .SERIAL_RX_WAKE(src[3]),
        .RTC_SECONDS_UNIT(src[4]), .RTC_PRESCALED_UNIT(src[5]), .WAKE_EN(en),
        .RET_DATA_EXTRA(ret[0]), .RET_INSTR_PAIR(ret[1]), .GPIO_CFG_DONE(cfg_done),
        .MODE(mode), .CORE_CLK_EN(core_clk), .CORE_RUN(core_run), .SYS_CLK_EN(sys_clk),
        .DMA_CLK_EN(dma_clk), .PERIPH_PWR_EN(periph), .STATE_RET_EN(st_ret),
        .SRAM_PWR_EN(sram_pwr), .SRAM_RET_EN(sram_ret), .GPIO_HOLD(hold),
        .GPIO_CFG_RET(cfg_ret), .GPIO_CFG_CLEAR(cfg_clr), .GPIO_TRISTATE(tri_st),
        .ICACHE_INVAL(inval));
    initial begin
        forever #4 MCLK = ~MCLK;
    end
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic check_vec(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_vec({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wait_mode(input logic [1:0] m, input int lim, output bit hit);
        hit = 1'b0;
        for (int n = 0; n < lim && !hit; n++) begin
            @(posedge MCLK);
            #1 hit = (mode === m);
        end
    endtask
    task automatic cfg_pulse();
        @(posedge MCLK);
        cfg_done <= 1'b1;
        @(posedge MCLK);
        cfg_done <= 1'b0;
        #1 check_bit(tri_st, 1'b0);
    endtask
    task automatic t_gated();
        core.request(REQ_CORE_GATED, 0);
        #1 check_vec({2'h0, mode, core_clk, core_run, sys_clk, dma_clk},
            8'h13);
        core.interrupt();
        #1 check_vec({6'h00, mode}, 8'h00);
        core.request(REQ_CORE_GATED, 3);
        core.request(REQ_HIBERNATE, 0);
        #1 check_vec({6'h00, mode}, 8'h01);
        core.request(REQ_ACTIVE, 0);
        #1 check_vec({6'h00, mode}, 8'h00);
    endtask
    // Wake during entry skips the long power-up wait
    task automatic t_early();
        bit hit;
        core.request(REQ_HIBERNATE, 0);
        src <= 6'h01;
        wait_mode(REQ_ACTIVE, 40, hit);
        check_bit(hit, 1'b0);
        wait_mode(REQ_ACTIVE, 30, hit);
        check_bit(hit, 1'b1);
        check_vec({5'h00, cfg_clr, inval, tri_st}, 8'h02);
        @(posedge MCLK);
        src <= 6'h00;
    endtask
    // The slow wake path is timed both ways: too early breaks settling
    task automatic t_wake(input logic [1:0] m, input int i, input bit dis);
        bit hit;
        bit sd;
        logic [5:0] ok;
        logic [3:0] keep;
        sd = (m == REQ_SHUTDOWN);
        ok = sd ? SD_WAKE_MASK : HIB_WAKE_MASK;
        @(posedge MCLK);
        en <= dis ? ~(6'h01 << i) : 6'h3f;
        ret <= ret + 2'h1;
        core.request(m, i);
        keep = BANK_ALWAYS | (ret[0] ? BANK_DATA_EXTRA : 4'h0);
        keep = keep | (ret[1] ? BANK_INSTR_PAIR : 4'h0);
        keep = sd ? 4'h0 : keep;
        repeat (ENTRY_CYC + 5) @(posedge MCLK);
        src <= 6'h01 << i;
        #1 check_vec({4'h0, hold, cfg_ret, mode}, {4'h0, 1'b1, !sd, m});
        check_vec({sram_pwr, sram_ret}, {keep, keep});
        check_bit(st_ret, !sd);
        wait_mode(REQ_ACTIVE, 290, hit);
        check_bit(hit, 1'b0);
        wait_mode(REQ_ACTIVE, 30, hit);
        check_bit(hit, ok[i] & !dis);
        if (!hit) begin
            @(posedge MCLK);
            src <= 6'h01 << ((i == 4) ? 0 : 4);
            wait_mode(REQ_ACTIVE, 320, hit);
            check_bit(hit, 1'b1);
        end
        check_vec({5'h00, cfg_clr, inval, tri_st}, {5'h00, sd, 1'b1, sd});
        if (sd) begin
            cfg_pulse();
        end
        @(posedge MCLK);
        src <= 6'h00;
    endtask
    initial begin
        repeat (12) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        #1 check_vec({2'h0, tri_st, hold, cfg_ret, st_ret, cfg_clr, inval}, 8'h20);
        check_vec({3'h0, core_clk, core_run, sys_clk, dma_clk, periph}, 8'h1f);
        check_vec({2'h0, mode, sram_pwr}, 8'h0f);
        check_vec({4'h0, sram_ret}, 8'h00);
        cfg_pulse();
        t_gated();
        t_early();
        for (int d = 0; d < 2; d++) begin
            for (int i = 0; i < 6; i++) begin
                t_wake(REQ_HIBERNATE, i, d[0]);
                t_wake(REQ_SHUTDOWN, i, d[0]);
            end
        end
        end_of_test();
    end
endmodule
